// ---- verilog/slow_osc_trim_pkg.sv ----
// Constants for the slow oscillator trim calibrator
package slow_osc_trim_pkg;
  // System clock rate
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned CLK_PERIOD_NS = 1000000000 / CLK_HZ;
  // Register byte offsets
  localparam logic [5:0] OFS_STATUS = 6'h00;
  localparam logic [5:0] OFS_CONTROL = 6'h04;
  localparam logic [5:0] OFS_UPPER = 6'h08;
  localparam logic [5:0] OFS_LOWER = 6'h0C;
  localparam logic [5:0] OFS_TRIM = 6'h10;
  localparam logic [5:0] OFS_TARGET = 6'h14;
  localparam logic [5:0] OFS_SLOW_CNT = 6'h18;
  localparam logic [5:0] OFS_EXPECTED = 6'h1C;
  localparam logic [5:0] OFS_MEASURED = 6'h20;
  // Field widths
  localparam int unsigned TRIM_W = 6;
  localparam int unsigned TGT_W = 3;
  localparam int unsigned CNT_W = 13;
  // Status bit positions
  localparam int unsigned ST_DEC = 5;
  localparam int unsigned ST_INC = 4;
  localparam int unsigned ST_MIN = 3;
  localparam int unsigned ST_MAX = 2;
  localparam int unsigned ST_OVF = 1;
  localparam int unsigned ST_DONE = 0;
  // Control bit positions
  localparam int unsigned CT_AUTO_CLR = 7;
  localparam int unsigned CT_HOLD = 6;
  localparam int unsigned CT_TOL = 5;
  localparam int unsigned CT_EN = 4;
  // Interrupt enables occupy control bits 3..0, aligned with status
  localparam logic [7:0] IRQ_EN_MASK = 8'h0F;
  // Reset values
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [5:0] UPPER_RST = 6'h3F;
  localparam logic [5:0] LOWER_RST = 6'h00;
  localparam logic [2:0] TARGET_RST = 3'h0;
  localparam logic [12:0] EXPECTED_RST = 13'h0000;
  localparam logic [12:0] MEASURED_RST = 13'h0000;
  // Tolerance base step: window is this times (1 + select)
  localparam logic [14:0] TOL_STEP = 15'h0010;
  // Saturated fast count marking an overflow
  localparam logic [13:0] FAST_SAT = 14'h2000;
  localparam logic [12:0] FAST_MAX = 13'h1FFF;
  // Calibration states
  typedef enum logic [0:0] {
    CAL_IDLE = 1'b0,
    CAL_MEASURE = 1'b1
  } cal_state_e;
endpackage

// ---- verilog/slow_osc_trim_calibrator.sv ----
// Slow oscillator trim calibrator with Avalon-MM register slave
// Functional notes
// - At period end compare measured with expected
// - Above expected plus window: trim up one
// - Below expected minus window: trim down one
// - Inside window: trim code unchanged
// - Tolerance select: 16 when zero, 32 one
// - Upper limit fixed; larger trim reverts to it
// - Lower limit writable, resets to zero
// - Fast oscillator off aborts cycle, trim kept
// - Reading status clears the flags that the read returned
// - Bit5 flags decrement decision, even if blocked
// - Bit4 flags increment decision, even if blocked
// - Bit3 lower limit reached, bit2 upper
// - Bit1 flags fast counter overflow
// - Bit0 set on every completed cycle
// - Auto clear drops enable after next cycle
// - Hold bit freezes trim, flags still reported
// - Control bit4 enables the calibrator
// - Control bits 3..0 enable the interrupts
// - Trim never decremented below lower limit
// - Target sets slow periods; zero disables
// - Trim moves at most one step per cycle
// - Measured count holds fast clocks per base
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module slow_osc_trim_calibrator
  import slow_osc_trim_pkg::*;
#(
  parameter logic [5:0] TRIM_RST = 6'h20, // Reset trim, arbitrary mid value
  parameter int unsigned MEAS_W = 13
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_slow_clk,
  input wire logic i_fast_osc_en,
  output logic [5:0] o_trim_code,
  output logic o_irq
);

  // Counter width must match the 13-bit count fields
  if (MEAS_W != CNT_W) begin : g_bad_width
    $error("MEAS_W must equal the 13-bit count field width");
  end

  typedef struct packed {
    cal_state_e state;
    logic slow_prev;
    logic ack;
    logic [31:0] rdata;
    logic [7:0] status;
    logic [7:0] control;
    logic [5:0] lower;
    logic [5:0] trim;
    logic [2:0] target;
    logic [2:0] slow_cnt;
    logic [12:0] expected;
    logic [12:0] measured;
    logic [13:0] fast_cnt;
  } state_s;

  localparam state_s ST_RST = '{
    state: CAL_IDLE,
    slow_prev: 1'b0,
    ack: 1'b0,
    rdata: 32'h0000_0000,
    status: STATUS_RST,
    control: CONTROL_RST,
    lower: LOWER_RST,
    trim: TRIM_RST,
    target: TARGET_RST,
    slow_cnt: 3'h0,
    expected: EXPECTED_RST,
    measured: MEASURED_RST,
    fast_cnt: 14'h0000
  };

  state_s st_q;
  state_s st_d;

  logic req;
  logic wr_go;
  logic rd_go;
  logic slow_rise;
  logic run_ok;
  logic finish;
  logic [13:0] fc_nx;
  logic [12:0] meas;
  logic [14:0] tol;
  logic [14:0] exp_hi;
  logic [14:0] meas_lo;
  logic go_up;
  logic go_down;
  logic [7:0] set_flags;
  logic [7:0] clr_flags;
  logic [5:0] wtrim;

  // Read mux, unmapped addresses read as zero
  function automatic logic [31:0] read_mux(input state_s s, input logic [5:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      OFS_STATUS: r[7:0] = s.status;
      OFS_CONTROL: r[7:0] = s.control;
      OFS_UPPER: r[5:0] = UPPER_RST;
      OFS_LOWER: r[5:0] = s.lower;
      OFS_TRIM: r[5:0] = s.trim;
      OFS_TARGET: r[2:0] = s.target;
      OFS_SLOW_CNT: r[2:0] = s.slow_cnt;
      OFS_EXPECTED: r[12:0] = s.expected;
      OFS_MEASURED: r[12:0] = s.measured;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  always_comb begin
    st_d = st_q;
    set_flags = 8'h00;
    clr_flags = 8'h00;
    finish = 1'b0;
    go_up = 1'b0;
    go_down = 1'b0;
    wtrim = i_avs_writedata[5:0];

    // Bus handshake: one wait cycle, then the access completes
    req = i_avs_read | i_avs_write;
    st_d.ack = req & ~st_q.ack;
    wr_go = i_avs_write & st_q.ack;
    rd_go = i_avs_read & st_q.ack;
    if (req && !st_q.ack) begin
      st_d.rdata = read_mux(st_q, i_avs_address);
    end

    // Slow clock is sampled; a rising edge marks one slow period
    st_d.slow_prev = i_slow_clk;
    slow_rise = i_slow_clk & ~st_q.slow_prev;

    // Measurement needs enable, a nonzero target and the fast oscillator
    run_ok = st_q.control[CT_EN] & (st_q.target != 3'h0) & i_fast_osc_en;

    // Fast count saturates one past the 13-bit range to mark overflow
    fc_nx = (st_q.fast_cnt == FAST_SAT) ? FAST_SAT : st_q.fast_cnt + 14'h0001;
    meas = fc_nx[13] ? FAST_MAX : fc_nx[12:0];

    // Window of 16 or 32 counts; 15-bit math avoids wrap at the ends
    tol = st_q.control[CT_TOL] ? (TOL_STEP << 1) : TOL_STEP;
    exp_hi = {2'b00, st_q.expected} + tol;
    meas_lo = {2'b00, meas} + tol;

    // Software writes, single byte lane per narrow register
    if (wr_go && i_avs_byteenable[0]) begin
      case (i_avs_address)
        OFS_CONTROL: st_d.control = i_avs_writedata[7:0];
        OFS_LOWER: st_d.lower = i_avs_writedata[5:0];
        OFS_TRIM: st_d.trim = (wtrim > UPPER_RST) ? UPPER_RST : wtrim;
        OFS_TARGET: st_d.target = i_avs_writedata[2:0];
        OFS_EXPECTED: st_d.expected[7:0] = i_avs_writedata[7:0];
        default: st_d.expected = st_d.expected;
      endcase
    end
    if (wr_go && i_avs_byteenable[1] && i_avs_address == OFS_EXPECTED) begin
      st_d.expected[12:8] = i_avs_writedata[12:8];
    end

    // Calibration sequencing
    case (st_q.state)
      CAL_IDLE: begin
        if (run_ok && slow_rise) begin
          st_d.state = CAL_MEASURE;
          st_d.slow_cnt = 3'h0;
          st_d.fast_cnt = 14'h0000;
        end
      end
      CAL_MEASURE: begin
        if (!run_ok) begin
          st_d.state = CAL_IDLE;
        end else begin
          st_d.fast_cnt = fc_nx;
          if (slow_rise) begin
            st_d.slow_cnt = st_q.slow_cnt + 3'h1;
            if (st_q.slow_cnt + 3'h1 == st_q.target) begin
              finish = 1'b1;
            end
          end
        end
      end
      default: st_d.state = CAL_IDLE;
    endcase

    // End of time base: decide, report, adjust
    if (finish) begin
      go_up = {2'b00, meas} > exp_hi;
      go_down = meas_lo < {2'b00, st_q.expected};
      st_d.measured = meas;
      set_flags[ST_DONE] = 1'b1;
      set_flags[ST_OVF] = fc_nx[13];
      set_flags[ST_INC] = go_up;
      set_flags[ST_DEC] = go_down;
      // Single step per cycle; hardware wins over a same-cycle trim write on a step or inside the window, not when hold or a limit blocks the step
      if (go_up) begin
        if (!st_q.control[CT_HOLD] && st_q.trim < UPPER_RST) begin
          st_d.trim = st_q.trim + 6'h01;
        end
        set_flags[ST_MAX] = (st_d.trim >= UPPER_RST);
      end else if (go_down) begin
        if (!st_q.control[CT_HOLD] && st_q.trim > st_q.lower) begin
          st_d.trim = st_q.trim - 6'h01;
        end
        set_flags[ST_MIN] = (st_d.trim <= st_q.lower);
      end else begin
        st_d.trim = st_q.trim;
      end
      // Restart the next period on this same slow edge
      st_d.slow_cnt = 3'h0;
      st_d.fast_cnt = 14'h0000;
      if (st_q.control[CT_AUTO_CLR]) begin
        st_d.control[CT_EN] = 1'b0;
        st_d.state = CAL_IDLE;
      end
    end

    // Clear on read only what the snapshot showed, so a flag raised in the
    // wait cycle is not lost; a flag raised in the same cycle survives
    if (rd_go && i_avs_address == OFS_STATUS) begin
      clr_flags = st_q.rdata[7:0];
    end
    st_d.status = ((st_q.status & ~clr_flags) | set_flags) & 8'h3F;
  end

  // Whole state registered in one place
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs
  assign o_avs_waitrequest = req & ~st_q.ack;
  assign o_avs_readdata = st_q.rdata;
  assign o_trim_code = st_q.trim;
  assign o_irq = |(st_q.status & st_q.control & IRQ_EN_MASK);

endmodule

// ---- tb/slow_osc_model.sv ----
// Slow oscillator model: a free running clock for the calibrator
`timescale 1ns/10ps
module slow_osc_model #(
  parameter int HALF = 32
) (
  input wire logic i_clk,
  output logic o_slow_clk
);
  int cnt = 0;
  initial o_slow_clk = 1'b0;
  // Fixed period keeps the measured count exact; trim is not modelled
  always @(posedge i_clk) begin
    if (cnt == HALF - 1) begin
      cnt <= 0;
      o_slow_clk <= ~o_slow_clk;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ---- tb/slow_osc_trim_props.sv ----
// Port assertions for the trim calibrator
`timescale 1ns/10ps
module slow_osc_trim_props import slow_osc_trim_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic i_slow_clk,
  input wire logic i_fast_osc_en,
  input wire logic [5:0] o_trim_code,
  input wire logic o_irq
);
  // Request, accepted read and write shorthands
  wire logic rq = i_avs_read | i_avs_write;
  wire logic rak = i_avs_read & ~o_avs_waitrequest;
  wire logic wak = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
  wire logic [5:0] wtrim = i_avs_writedata[5:0];
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);
  // Bus handshake
  AST_ACK_ONE:
    assert property (rq && o_avs_waitrequest |=> !o_avs_waitrequest) else $error("no answer");
  AST_IDLE:
    assert property (!rq |-> !o_avs_waitrequest) else $error("wait while idle");
  AST_NO_MAP:
    assert property (rak && i_avs_address > OFS_MEASURED |-> o_avs_readdata == 0)
    else $error("unmapped read");
  AST_UPPER:
    assert property (rak && i_avs_address == OFS_UPPER |-> o_avs_readdata == 32'h3F)
    else $error("upper limit moved");
  // Slow edges quiet for three cycles, so hardware cannot win the edge
  AST_TRIM_WR:
    assert property (wak && i_avs_address == OFS_TRIM && !i_slow_clk && !$past(i_slow_clk)
      && !$past(i_slow_clk, 2) |=> o_trim_code == $past(wtrim)) else $error("trim write");
  AST_STEP:
    assert property ($changed(o_trim_code) && !$past(i_avs_write) |->
      o_trim_code - $past(o_trim_code) == 6'h01 || $past(o_trim_code) - o_trim_code == 6'h01)
    else $error("trim jumped");
  AST_FAST_OFF:
    assert property (!i_fast_osc_en && !$past(i_fast_osc_en) && !$past(i_avs_write) |->
      $stable(o_trim_code)) else $error("trim moved while fast clock off");
  AST_RD_CLR:
    assert property (rak && i_avs_address == OFS_STATUS && !i_slow_clk && !$past(i_slow_clk)
      && !$past(i_slow_clk, 2) |=> !o_irq) else $error("irq after status read");
  cover property ($rose(o_irq));
  cover property (o_trim_code == $past(o_trim_code) + 6'h01);
  cover property (o_trim_code == $past(o_trim_code) - 6'h01);
endmodule
bind slow_osc_trim_calibrator slow_osc_trim_props u_props (.i_sys_clk, .i_sys_rst,
  .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
  .o_avs_readdata, .o_avs_waitrequest, .i_slow_clk, .i_fast_osc_en, .o_trim_code, .o_irq);

// ---- tb/test_slow_osc_trim_calibrator.sv ----
// Self-checking bench for the trim calibrator
`timescale 1ns/10ps
module test_slow_osc_trim_calibrator import slow_osc_trim_pkg::*;;
  typedef struct packed {
    logic [12:0] e;
    logic [7:0] c;
    logic [7:0] s;
    logic [5:0] t;
  } row_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic fen = 1'b1;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wreq;
  logic slow;
  logic irq;
  logic [5:0] trim;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  // Slow period is 64 clocks and the target is 2, so 128 clocks are measured
  row_s rows [9] = '{'{13'h64, 8'h00, 8'h11, 6'h21}, '{13'h70, 8'h00, 8'h01, 6'h21},
    '{13'h6F, 8'h00, 8'h11, 6'h22}, '{13'h96, 8'h00, 8'h21, 6'h21},
    '{13'h64, 8'h20, 8'h01, 6'h21}, '{13'h5F, 8'h20, 8'h11, 6'h22},
    '{13'hB0, 8'h20, 8'h21, 6'h21}, '{13'h64, 8'h40, 8'h11, 6'h21},
    '{13'hA0, 8'h40, 8'h21, 6'h21}};
  logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h3F, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] lt [2] = '{8'h3F, 8'h10};
  logic [7:0] le [2] = '{8'h64, 8'h96};
  logic [7:0] ls [2] = '{8'h15, 8'h29};
  logic [7:0] it [3] = '{8'h00, 8'h02, 8'h02};
  logic [7:0] ic [3] = '{8'h91, 8'h01, 8'h9E};
  logic [7:0] is [3] = '{8'h00, 8'h00, 8'h01};
  initial forever #20 clk = ~clk;
  slow_osc_trim_calibrator u_dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_slow_clk(slow),
    .i_fast_osc_en(fen), .o_trim_code(trim), .o_irq(irq));
  slow_osc_model u_osc (.i_clk(clk), .o_slow_clk(slow));
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Request stands until the edge that sees waitrequest low; data is taken there
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 0, r);
    check($sformatf("reg %h", a), r, e);
  endtask
  task automatic wait_done();
    for (int k = 0; k < 400 && irq !== 1'b1; k++)
      @(posedge clk);
    check("irq", 32'(irq), 1);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // A hang counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // Auto clear with the done interrupt makes each row one cycle
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++)
      rd_chk(6'(i * 4), rv[i]);
    wr_reg(OFS_UPPER, 8'h10);
    rd_chk(OFS_UPPER, 8'h3F);
    rd_chk(6'h24, 0);
    wr_reg(OFS_TARGET, 2);
    foreach (rows[i]) begin
      wr_reg(OFS_EXPECTED, rows[i].e);
      wr_reg(OFS_CONTROL, rows[i].c | 8'h91);
      wait_done();
      rd_chk(OFS_STATUS, rows[i].s);
      rd_chk(OFS_STATUS, 0);
      check("trim", 32'(trim), 32'(rows[i].t));
      rd_chk(OFS_MEASURED, 8'h80);
      rd_chk(OFS_CONTROL, rows[i].c | 8'h81);
    end
    wr_reg(OFS_LOWER, 8'h10);
    rd_chk(OFS_LOWER, 8'h10);
    for (int i = 0; i < 2; i++) begin
      wr_reg(OFS_TRIM, lt[i]);
      wr_reg(OFS_EXPECTED, le[i]);
      wr_reg(OFS_CONTROL, 8'h91);
      wait_done();
      rd_chk(OFS_STATUS, ls[i]);
      rd_chk(OFS_TRIM, lt[i]);
    end
    // Drop the fast clock once the cycle is surely running
    wr_reg(OFS_CONTROL, 8'h91);
    repeat (100) @(posedge clk);
    fen <= 1'b0;
    repeat (300) @(posedge clk);
    rd_chk(OFS_STATUS, 0);
    rd_chk(OFS_TRIM, 8'h10);
    wr_reg(OFS_CONTROL, 0);
    fen <= 1'b1;
    wr_reg(OFS_EXPECTED, 8'h80);
    for (int i = 0; i < 3; i++) begin
      wr_reg(OFS_TARGET, it[i]);
      wr_reg(OFS_CONTROL, ic[i]);
      repeat (300) @(posedge clk);
      check("irq", 32'(irq), 0);
      rd_chk(OFS_STATUS, is[i]);
      wr_reg(OFS_CONTROL, 0);
    end
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("trim", 32'(trim), 8'h20);
    rd_chk(OFS_LOWER, 0);
    tally_and_finish();
  end
endmodule
